//--- pkg/vslm_defs.svh
`ifndef VSLM_DEFS_SVH
`define VSLM_DEFS_SVH

// Diagnostic byte addresses of the published source information.
`define VSLM_OFS_SRC_TYPE      8'h19
`define VSLM_OFS_TOT_PIX       8'h1a
`define VSLM_OFS_TOT_LINES     8'h1c
`define VSLM_OFS_ACT_PIX       8'h1e
`define VSLM_OFS_ACT_LINES     8'h20
`define VSLM_OFS_LAST          8'h21

// Source type byte fields.
`define VSLM_SRC_LOST_BIT      3
`define VSLM_SRC_NONE          3'h0
`define VSLM_SRC_PARALLEL      3'h1
`define VSLM_SRC_OLDI          3'h2
`define VSLM_SRC_TPG           3'h3
`define VSLM_SRC_SPLASH        3'h4

// Error codes.
`define VSLM_ERR_LINES         12'd665
`define VSLM_ERR_PIXELS        12'd666
`define VSLM_ERR_PCLK_OLDI     12'd671
`define VSLM_ERR_PCLK_PAR      12'd674
`define VSLM_ERR_PCLK_HIGH     12'd676
`define VSLM_ERR_PCLK_LOW      12'd677
`define VSLM_ERR_VS_HIGH       12'd678
`define VSLM_ERR_VS_LOW        12'd679
`define VSLM_ERR_LOST          12'd913
`define VSLM_ERR_LOST_ALT      12'd914
`define VSLM_ERR_VS_TIMEOUT    12'd946

// Missing vsync timeout: time in microseconds and cycles at 40 MHz.
`define VSLM_CLK_MHZ           40
`define VSLM_VS_TIMEOUT_US     100000
`define VSLM_VS_TIMEOUT_CYC    (`VSLM_VS_TIMEOUT_US * `VSLM_CLK_MHZ)

`endif

//--- pkg/vslm_pkg.sv
package vslm_pkg;

    typedef enum logic [1:0] {
        VSLM_ST_STANDBY,
        VSLM_ST_EXTERNAL,
        VSLM_ST_ALTERNATE,
        VSLM_ST_DARK
    } vslm_mode_t;

    typedef struct packed {
        logic [31:0] pclk_min;
        logic [31:0] pclk_max;
        logic [31:0] vs_min;
        logic [31:0] vs_max;
        logic [15:0] act_lines;
        logic [15:0] act_pixels;
        logic        auto_recover;
        logic        alt_is_splash;
        logic        port_is_oldi;
    } vslm_cfg_t;

    typedef struct packed {
        logic        vs;
        logic        hs;
        logic        de;
        logic        pclk;
    } vslm_vid_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] code;
    } vslm_err_t;

    typedef struct packed {
        vslm_vid_t   s1;
        vslm_vid_t   s2;
        vslm_vid_t   s3;
        vslm_mode_t  mode;
        logic        seen_valid;
        logic        failed;
        logic [31:0] frm_cyc;
        logic [15:0] pclk_cnt;
        logic [31:0] pclk_frm;
        logic [15:0] pix_cnt;
        logic [15:0] tot_pix_cnt;
        logic [15:0] line_cnt;
        logic [15:0] tot_line_cnt;
        logic [15:0] last_pix;
        logic [15:0] last_tot_pix;
        logic        frame_ok;
        logic        have_frame;
        logic [11:0] frm_code;
        logic [8:0][7:0] mem;
        vslm_err_t   err;
        logic        illum;
        logic [7:0]  rd_data;
    } vslm_state_t;

endpackage

//--- src/vslm_monitor.sv
`timescale 1ns/10ps
// Behaviour
// RQ1: Each frame check vsync, pixel clock, active lines and active pixels while external.
// RQ2: Vsync frequency outside configured min/max fails the source.
// RQ3: Pixel clock frequency outside configured limits fails the source.
// RQ4: Active line count unequal to vertical resolution flags failure.
// RQ5: Active pixel count unequal to horizontal resolution flags failure.
// RQ6: Auto-recover zero keeps alternate image until host selects external again.
// RQ7: Auto-recover one returns to external video once checks pass.
// RQ8: Failure of an initially good source shows the configured alternate image.
// RQ9: Source bad during configuration or move to display shows no image.
// RQ10: Standby to display with bad source stays in standby, logs error.
// RQ11: Source select with bad source disables illumination, logs error.
// RQ12: Valid source turning invalid shows alternate image, logs error.
// RQ13: Invalid source turning valid returns to external only with auto-recover.
// RQ14: Distinct error codes for line count and pixel count mismatch.
// RQ15: Separate pixel clock error codes for OpenLDI and parallel ports.
// RQ16: Distinct error codes for pixel clock above and below range.
// RQ17: Distinct error codes for vsync above maximum and below minimum.
// RQ18: Codes for source lost, and lost with failed alternate switch.
// RQ19: Dedicated code when expected vsync does not arrive in time.
// RQ20: Byte 25 holds source type with lost flag in bit 3.
// RQ21: Bytes 26 to 33 hold source timing, zero while internal image shown.
// RQ22: Diagnostic clear zeroes selected bytes until the next update.
// RQ23: Count lines and pixels per frame, latch at each vsync edge.
`include "vslm_defs.svh"
module vslm_monitor
    import vslm_pkg::*;
#(
    parameter int unsigned VS_TIMEOUT_CYC = `VSLM_VS_TIMEOUT_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire vslm_vid_t  vid_in,
    input  wire vslm_cfg_t  cfg,
    input  wire logic       display_req,
    input  wire logic       standby_req,
    input  wire logic       source_sel_req,
    input  wire logic       alt_fail,
    input  wire logic [7:0] diag_addr,
    input  wire logic       diag_clr,
    output logic [7:0]      diag_rdata,
    output vslm_mode_t      mode,
    output logic            illum_en,
    output vslm_err_t       err
);

    vslm_state_t r;
    vslm_state_t n;

    logic       vs_rise;
    logic       hs_rise;
    logic       de_fall;
    logic       pclk_rise;
    logic       timeout;
    logic       lines_bad;
    logic       pix_bad;
    logic       pclk_hi;
    logic       pclk_lo;
    logic       vs_hi;
    logic       vs_lo;
    logic       src_ok;
    logic [2:0] src_code;
    logic [7:0] src_byte;
    logic [11:0] code;

    // Inputs come from the source's domain; s1 feeds only s2.
    assign vs_rise   = r.s2.vs & ~r.s3.vs;
    assign hs_rise   = r.s2.hs & ~r.s3.hs;
    assign de_fall   = ~r.s2.de & r.s3.de;
    assign pclk_rise = r.s2.pclk & ~r.s3.pclk;
    assign timeout   = r.frm_cyc >= VS_TIMEOUT_CYC;

    always_comb begin
        // Frame period in sys cycles and pixel clocks per frame at vsync.
        lines_bad = r.line_cnt != cfg.act_lines; // RQ4
        pix_bad   = r.last_pix != cfg.act_pixels; // RQ5
        pclk_hi   = r.pclk_frm > cfg.pclk_max; // RQ3
        pclk_lo   = r.pclk_frm < cfg.pclk_min; // RQ3
        // Vsync frequency is inverse to frame period.
        vs_hi     = r.frm_cyc < cfg.vs_min; // RQ2
        vs_lo     = r.frm_cyc > cfg.vs_max; // RQ2
        src_ok    = !(lines_bad || pix_bad || pclk_hi || pclk_lo || vs_hi || vs_lo);
        code      = 12'h000;
        if (vs_lo) begin
            code = `VSLM_ERR_VS_LOW; // RQ17
        end else if (vs_hi) begin
            code = `VSLM_ERR_VS_HIGH; // RQ17
        end else if (pclk_hi) begin
            code = `VSLM_ERR_PCLK_HIGH; // RQ16
        end else if (pclk_lo) begin
            code = `VSLM_ERR_PCLK_LOW; // RQ16
        end else if (lines_bad) begin
            code = `VSLM_ERR_LINES; // RQ14
        end else if (pix_bad) begin
            code = `VSLM_ERR_PIXELS; // RQ14
        end
    end

    always_comb begin
        case (r.mode)
            VSLM_ST_EXTERNAL: src_code = cfg.port_is_oldi ? `VSLM_SRC_OLDI : `VSLM_SRC_PARALLEL;
            VSLM_ST_ALTERNATE: src_code = cfg.alt_is_splash ? `VSLM_SRC_SPLASH : `VSLM_SRC_TPG;
            default: src_code = `VSLM_SRC_NONE;
        endcase
        src_byte = {5'h00, src_code};
        src_byte[`VSLM_SRC_LOST_BIT] = r.failed; // RQ20
    end

    always_comb begin
        n = r;
        n.s1 = vid_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.err.valid = 1'b0;
        n.err.code  = r.err.code;
        if (!timeout) begin
            n.frm_cyc = r.frm_cyc + 32'h1;
        end
        if (pclk_rise) begin
            n.pclk_cnt    = r.pclk_cnt + 16'h1;
            n.pclk_frm    = r.pclk_frm + 32'h1;
            n.tot_pix_cnt = r.tot_pix_cnt + 16'h1;
            if (r.s2.de) begin
                n.pix_cnt = r.pix_cnt + 16'h1; // RQ23
            end
        end
        if (de_fall) begin
            n.line_cnt = r.line_cnt + 16'h1; // RQ23
            n.last_pix = r.pix_cnt; // RQ23
            n.pix_cnt  = 16'h0;
        end
        if (hs_rise) begin
            n.tot_line_cnt = r.tot_line_cnt + 16'h1;
            n.last_tot_pix = r.tot_pix_cnt;
            n.tot_pix_cnt  = 16'h0;
        end

        if (vs_rise) begin
            // One full frame evaluated per vsync edge.
            n.frame_ok   = src_ok; // RQ1
            n.have_frame = 1'b1;
            n.frm_cyc    = 32'h0;
            n.pclk_frm   = 32'h0;
            n.line_cnt   = 16'h0;
            // The first line's hsync shares this edge, so it counts as line one.
            n.tot_line_cnt = hs_rise ? 16'h1 : 16'h0;
            // The reason for this verdict is kept for requests refused later.
            n.frm_code   = code;
            n.pix_cnt    = 16'h0;
            if (r.mode == VSLM_ST_EXTERNAL && src_ok) begin
                {n.mem[1], n.mem[2]} = {r.last_tot_pix[7:0], r.last_tot_pix[15:8]}; // RQ21
                {n.mem[3], n.mem[4]} = {r.tot_line_cnt[7:0], r.tot_line_cnt[15:8]}; // RQ21
                {n.mem[5], n.mem[6]} = {r.last_pix[7:0], r.last_pix[15:8]}; // RQ21
                {n.mem[7], n.mem[8]} = {r.line_cnt[7:0], r.line_cnt[15:8]}; // RQ21
            end
        end else if (timeout) begin
            n.frame_ok   = 1'b0;
            n.have_frame = 1'b1;
        end

        case (r.mode)
            VSLM_ST_STANDBY: begin
                if (display_req) begin
                    if (r.frame_ok && !timeout) begin
                        n.mode  = VSLM_ST_EXTERNAL; // RQ10
                        n.illum = 1'b1;
                        n.failed = 1'b0;
                    end else begin
                        n.err.valid = 1'b1; // RQ10 RQ9
                        n.err.code  = timeout ? `VSLM_ERR_VS_TIMEOUT : r.frm_code;
                    end
                end
            end
            VSLM_ST_EXTERNAL: begin
                if (timeout || (vs_rise && !src_ok)) begin
                    // A source already bad when selected gets no image.
                    n.err.valid = 1'b1; // RQ12
                    n.failed    = 1'b1;
                    if (!r.seen_valid) begin
                        n.mode  = VSLM_ST_DARK; // RQ9
                        n.illum = 1'b0;
                        n.err.code = timeout ? `VSLM_ERR_VS_TIMEOUT : code;
                    end else if (alt_fail) begin
                        n.mode  = VSLM_ST_DARK;
                        n.illum = 1'b0;
                        n.err.code = `VSLM_ERR_LOST_ALT; // RQ18
                    end else begin
                        n.mode  = VSLM_ST_ALTERNATE; // RQ8 RQ12
                        n.err.code = timeout ? `VSLM_ERR_VS_TIMEOUT : // RQ19
                                     (pclk_hi || pclk_lo) ?
                                     (cfg.port_is_oldi ? `VSLM_ERR_PCLK_OLDI
                                                       : `VSLM_ERR_PCLK_PAR) // RQ15
                                     : `VSLM_ERR_LOST; // RQ18
                    end
                end else if (vs_rise) begin
                    n.seen_valid = 1'b1;
                end
            end
            VSLM_ST_ALTERNATE, VSLM_ST_DARK: begin
                if (cfg.auto_recover && vs_rise && src_ok && r.seen_valid) begin
                    n.mode   = VSLM_ST_EXTERNAL; // RQ7 RQ13
                    n.illum  = 1'b1;
                    n.failed = 1'b0;
                end
            end
            default: n.mode = VSLM_ST_STANDBY;
        endcase

        // Host source select outside standby re-enters external video if the last frame passed, else goes dark (RQ6 release path).
        if (source_sel_req && r.mode != VSLM_ST_STANDBY) begin
            if (r.frame_ok && !timeout) begin
                n.mode   = VSLM_ST_EXTERNAL; // RQ6
                n.illum  = 1'b1;
                n.failed = 1'b0;
                n.seen_valid = 1'b0;
            end else begin
                n.mode  = VSLM_ST_DARK; // RQ11
                n.illum = 1'b0;
                n.err.valid = 1'b1; // RQ11
                n.err.code  = timeout ? `VSLM_ERR_VS_TIMEOUT : r.frm_code;
            end
        end
        if (standby_req) begin
            n.mode  = VSLM_ST_STANDBY;
            n.illum = 1'b0;
            n.seen_valid = 1'b0;
        end

        // Source change rewrites the type byte; timing zeroed when internal.
        if (n.mode != r.mode || n.failed != r.failed) begin
            n.mem[0] = src_byte; // RQ20
            if (n.mode != VSLM_ST_EXTERNAL) begin
                for (int i = 1; i < 9; i++) begin
                    n.mem[i] = 8'h00; // RQ21
                end
            end
        end
        n.mem[0] = (r.mem[0] != src_byte) ? src_byte : n.mem[0];
        if (diag_clr && diag_addr >= `VSLM_OFS_SRC_TYPE && diag_addr <= `VSLM_OFS_LAST) begin
            n.mem[diag_addr - `VSLM_OFS_SRC_TYPE] = 8'h00; // RQ22
        end

        if (diag_addr >= `VSLM_OFS_SRC_TYPE && diag_addr <= `VSLM_OFS_LAST) begin
            n.rd_data = r.mem[diag_addr - `VSLM_OFS_SRC_TYPE];
        end else begin
            n.rd_data = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign diag_rdata = r.rd_data;
    assign mode       = r.mode;
    assign illum_en   = r.illum;
    assign err        = r.err;

endmodule

//--- dv/vslm_src_model.sv
`timescale 1ns/10ps
module vslm_src_model
    import vslm_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       run,
    input  wire logic [2:0] half,
    input  wire logic [3:0] ap,
    input  wire logic [3:0] al,
    output vslm_vid_t       vid
);
    // Eight pixel clocks a line, six lines a frame, sync across line 0.
    int px = 0;
    int ln = 0;
    initial vid = '0;
    always begin
        repeat (half) @(posedge clk_sys);
        #1;
        vid.pclk = run & ~vid.pclk;
        // Data moves on the falling pixel clock so the rising one sees it settled.
        if (run && !vid.pclk) begin
            px = (px + 1) % 8;
            ln = (px == 0) ? (ln + 1) % 6 : ln;
            vid.vs = (ln == 0);
            vid.hs = (px == 0);
            vid.de = px >= 2 && px < 2 + ap && ln >= 1 && ln < 1 + al;
        end
    end
endmodule

//--- dv/vslm_monitor_asserts.sv
`timescale 1ns/10ps
module vslm_monitor_asserts
    import vslm_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       display_req,
    input wire logic       standby_req,
    input wire logic       source_sel_req,
    input wire vslm_cfg_t  cfg,
    input wire logic [7:0] diag_addr,
    input wire logic [7:0] diag_rdata,
    input wire vslm_mode_t mode,
    input wire logic       illum_en,
    input wire vslm_err_t  err
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire logic idle = !display_req && !standby_req && !source_sel_req;

    AST_ERR_PULSE: assert property (err.valid |=> !err.valid)
        else $error("error pulse too long");
    AST_ERR_CODE: assert property (err.valid |-> err.code inside
        {[12'h299:12'h2a7], 12'h391, 12'h392, 12'h3b2}) else $error("unknown code");
    AST_EXT_REQ: assert property (mode == VSLM_ST_STANDBY ##1 mode == VSLM_ST_EXTERNAL
        |-> $past(display_req) || $past(display_req, 2)) else $error("display unasked");
    AST_STBY_REQ: assert property (standby_req |-> ##[1:2] mode == VSLM_ST_STANDBY)
        else $error("standby ignored");
    AST_STBY_DARK: assert property (mode == VSLM_ST_STANDBY |-> !illum_en)
        else $error("lit in standby");
    AST_ALT_ERR: assert property (mode == VSLM_ST_EXTERNAL ##1 mode == VSLM_ST_ALTERNATE
        |-> err.valid || $past(err.valid)) else $error("silent switch");
    AST_NO_AUTO: assert property (mode == VSLM_ST_ALTERNATE && !cfg.auto_recover && idle
        && $past(idle) |=> mode != VSLM_ST_EXTERNAL) else $error("left alternate");
    AST_UNMAPPED: assert property (!(diag_addr inside {[8'h19:8'h21]}) |=> !diag_rdata)
        else $error("unmapped byte not zero");

    cover property (mode == VSLM_ST_ALTERNATE ##1 mode == VSLM_ST_EXTERNAL);
    cover property (err.valid && err.code == 12'h391);
    cover property (mode == VSLM_ST_STANDBY ##1 mode == VSLM_ST_EXTERNAL);
endmodule

//--- dv/vslm_monitor_tb.sv
`timescale 1ns/10ps
`include "vslm_defs.svh"
module vslm_monitor_tb
    import vslm_pkg::*;
;
    typedef struct packed {
        logic [2:0]  half;
        logic [3:0]  ap;
        logic [3:0]  al;
        logic [7:0]  pmin;
        logic [7:0]  pmax;
        logic        run;
        vslm_mode_t  md;
        logic [11:0] code;
    } vslm_row_t;
    localparam vslm_row_t ROWS [8] = '{
        '{3'h3, 4'h4, 4'h4, 8'h2e, 8'h32, 1'b1, VSLM_ST_STANDBY, `VSLM_ERR_VS_HIGH},
        '{3'h5, 4'h4, 4'h4, 8'h2e, 8'h32, 1'b1, VSLM_ST_STANDBY, `VSLM_ERR_VS_LOW},
        '{3'h4, 4'h4, 4'h4, 8'h2e, 8'h28, 1'b1, VSLM_ST_STANDBY, `VSLM_ERR_PCLK_HIGH},
        '{3'h4, 4'h4, 4'h4, 8'h32, 8'h3c, 1'b1, VSLM_ST_STANDBY, `VSLM_ERR_PCLK_LOW},
        '{3'h4, 4'h4, 4'h3, 8'h2e, 8'h32, 1'b1, VSLM_ST_STANDBY, `VSLM_ERR_LINES},
        '{3'h4, 4'h3, 4'h4, 8'h2e, 8'h32, 1'b1, VSLM_ST_STANDBY, `VSLM_ERR_PIXELS},
        '{3'h4, 4'h4, 4'h4, 8'h2e, 8'h32, 1'b0, VSLM_ST_STANDBY, `VSLM_ERR_VS_TIMEOUT},
        '{3'h4, 4'h4, 4'h4, 8'h2e, 8'h32, 1'b1, VSLM_ST_EXTERNAL, 12'h000}};
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    vslm_cfg_t   cfg;
    logic [2:0]  reqs = 3'h0;
    logic        alt_fail = 1'b0;
    logic [7:0]  diag_addr = 8'h00;
    logic        diag_clr = 1'b0;
    logic        run = 1'b1;
    logic [2:0]  half = 3'h4;
    logic [3:0]  ap = 4'h4;
    logic [3:0]  al = 4'h4;
    vslm_vid_t   vid;
    logic [7:0]  diag_rdata;
    vslm_mode_t  mode;
    logic        illum_en;
    vslm_err_t   err;
    logic        seen_v = 1'b0;
    logic [11:0] seen_c = 12'h000;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;

    vslm_src_model src_u (.clk_sys, .run, .half, .ap, .al, .vid);
    vslm_monitor #(.VS_TIMEOUT_CYC(2000)) dut_u (.clk_sys, .rst, .vid_in(vid), .cfg,
        .display_req(reqs[0]), .standby_req(reqs[1]), .source_sel_req(reqs[2]),
        .alt_fail, .diag_addr, .diag_clr, .diag_rdata, .mode, .illum_en, .err);

    initial forever #12.5 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (err.valid === 1'b1) begin
            seen_v = 1'b1;
            seen_c = err.code;
        end
        if (cyc == 60000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic req(input logic [2:0] r);
        seen_v = 1'b0;
        seen_c = 12'h000;
        reqs = r;
        tick(1);
        reqs = 3'h0;
        tick(4);
    endtask
    task automatic wm(input vslm_mode_t md);
        for (int i = 0; i < 3000 && mode !== md; i++)
            tick(1);
        // Let the error monitor take the pulse that came with the change.
        tick(1);
        chk("mode", 16'(mode), 16'(md));
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        diag_addr = a;
        tick(2);
        chk("diag byte", 16'(diag_rdata), 16'(e));
    endtask

    initial begin
        cfg = '{32'h2e, 32'h32, 32'h172, 32'h190, 16'h4, 16'h4, 1'b0, 1'b0, 1'b0};
        tick(20);
        rst = 1'b0;
        foreach (ROWS[i]) begin
            {half, ap, al, run} = {ROWS[i].half, ROWS[i].ap, ROWS[i].al, ROWS[i].run};
            cfg.pclk_min = 32'(ROWS[i].pmin);
            cfg.pclk_max = 32'(ROWS[i].pmax);
            tick(2400);
            req(3'h1);
            chk("row mode", 16'(mode), 16'(ROWS[i].md));
            chk("row code", {3'h0, seen_v, seen_c}, {3'h0, |ROWS[i].code, ROWS[i].code});
            $display("row %0d done", i);
        end
        rd(8'h19, 8'h01);
        // Timing bytes are written only at a good frame end while external.
        tick(800);
        rd(8'h1a, 8'h08);
        rd(8'h1d, 8'h00);
        rd(8'h1c, 8'h06);
        rd(8'h1e, 8'h04);
        rd(8'h20, 8'h04);
        rd(8'h22, 8'h00);
        diag_clr = 1'b1;
        rd(8'h1a, 8'h00);
        diag_clr = 1'b0;
        al = 4'h3;
        wm(VSLM_ST_ALTERNATE);
        chk("lost code", 16'(seen_c), 16'(`VSLM_ERR_LOST));
        rd(8'h19, 8'h0b);
        rd(8'h1e, 8'h00);
        al = 4'h4;
        tick(1600);
        chk("held", 16'(mode), 16'(VSLM_ST_ALTERNATE));
        req(3'h4);
        wm(VSLM_ST_EXTERNAL);
        // One good frame first, so that a later failure counts as a loss.
        tick(800);
        $display("diag and lost done");
        cfg.alt_is_splash = 1'b1;
        for (int p = 0; p < 2; p++) begin
            cfg.port_is_oldi = p[0];
            cfg.auto_recover = 1'b1;
            seen_c = 12'h000;
            cfg.pclk_max = 32'h28;
            wm(VSLM_ST_ALTERNATE);
            chk("port code", 16'(seen_c), p ? 16'(`VSLM_ERR_PCLK_OLDI) : 16'h2a2);
            rd(8'h19, 8'h0c);
            cfg.pclk_max = 32'h32;
            wm(VSLM_ST_EXTERNAL);
        end
        rd(8'h19, 8'h02);
        alt_fail = 1'b1;
        seen_c = 12'h000;
        al = 4'h3;
        tick(1200);
        chk("alt fail code", 16'(seen_c), 16'(`VSLM_ERR_LOST_ALT));
        alt_fail = 1'b0;
        req(3'h4);
        chk("illum", 16'(illum_en), 16'h0);
        chk("select err", 16'(seen_v), 16'h1);
        req(3'h2);
        chk("standby", 16'(mode), 16'(VSLM_ST_STANDBY));
        al = 4'h4;
        tick(1600);
        req(3'h1);
        wm(VSLM_ST_EXTERNAL);
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        chk("reset mode", {14'h0, mode}, 16'h0);
        rd(8'h19, 8'h00);
        $display("recovery and reset done");
        conclude();
    end
endmodule

bind vslm_monitor vslm_monitor_asserts chk_u (.clk_sys, .rst, .display_req, .standby_req,
    .source_sel_req, .cfg, .diag_addr, .diag_rdata, .mode, .illum_en, .err);
